// >>> design/ebc_bus_ctrl.sv
// External expansion bus control signals: strobes, bus clock, mode straps, port E.
//
// Overview of operation
// - Data bus enable strobe low only in bus clock high phase, unstretched cycle.
// - Strobe separates multiplexed address output from read data input.
// - Stretched access: strobe only in last quarter of last stretch period.
// - Strobe appears on port E bit 7 only when its assignment bit selects it.
// - Expanded mode at reset enables the strobe with no software action.
// - Low-byte strobe is XNOR of address bit zero and byte-size signal.
// - Read/write pin shows transfer direction in expanded modes.
// - Bus clock is driven out as timing and demultiplex reference.
// - Two mode pins sampled at reset choose the operating mode.
// - After reset mode pins become queue tracking outputs or general I/O.
// - Queue state is time-multiplexed over the two tracking outputs.
// - Debug pin level at reset chooses special or normal mode.
// - Read/write pin stays input and writes are refused until enabled.
// - Low-byte strobe not driven and low-byte writes refused until enabled.
// - Narrow mode splits a 16-bit transfer into high then low byte cycles.
//
// Added by the designer: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none

module ebc_bus_ctrl (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire logic acc_valid,
    input wire ebc_pkg::ebc_req_t acc_req,
    output logic acc_ready,
    output logic acc_done,
    output logic acc_refused,
    output logic [15:0] acc_rdata,
    input wire logic [3:0] queue_state,
    input wire logic single_wire_debug_pin,
    input wire logic [7:0] pe_pin_in,
    output logic [7:0] pe_pin_out,
    output logic [7:0] pe_pin_oe,
    input wire logic [15:0] bus_ad_in,
    output logic [15:0] bus_ad_out,
    output logic [1:0] bus_ad_oe
);
    import ebc_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_HIGH = 2'b01,
        ST_LOW = 2'b10
    } ebc_state_t;

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    logic [7:0] pe_meta;
    logic [7:0] pe_sync;
    logic dbg_meta;
    logic dbg_sync;
    logic [15:0] ad_meta;
    logic [15:0] ad_sync;

    // All pins come from outside the clock domain, so two flops each.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pe_meta <= 8'h00;
            pe_sync <= 8'h00;
            dbg_meta <= 1'b1;
            dbg_sync <= 1'b1;
            ad_meta <= 16'h0000;
            ad_sync <= 16'h0000;
        end else begin
            pe_meta <= pe_pin_in;
            pe_sync <= pe_meta;
            dbg_meta <= single_wire_debug_pin;
            dbg_sync <= dbg_meta;
            ad_meta <= bus_ad_in;
            ad_sync <= ad_meta;
        end
    end

    // ************************************************************
    // Mode straps
    // ************************************************************
    logic [1:0] strap_cnt;
    logic strap_done;
    ebc_mode_t mode;
    logic special;
    logic expanded;
    logic narrow;

    // Straps are taken once the synchronisers hold post-release pin levels.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            strap_cnt <= 2'h0;
            strap_done <= 1'b0;
            mode <= EBC_SINGLE;
            special <= 1'b0;
        end else if (!strap_done) begin
            strap_cnt <= strap_cnt + 2'h1;
            if (strap_cnt == STRAP_WAIT) begin
                strap_done <= 1'b1;
                mode <= ebc_mode_t'({pe_sync[PE_MODE_SELECT_B], pe_sync[PE_MODE_SELECT_A]});
                special <= ~dbg_sync;
            end
        end
    end

    assign expanded = strap_done && (mode == EBC_NARROW || mode == EBC_WIDE);
    assign narrow = (mode == EBC_NARROW);

    // ************************************************************
    // Registers
    // ************************************************************
    logic [7:0] assign_reg;
    logic [7:0] dir_reg;
    logic [7:0] data_reg;
    logic busy;

    // The strobe-off bit is reloaded at strap time, so expanded modes start with it clear.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            assign_reg <= ASSIGN_RESET;
        end else if (!strap_done && strap_cnt == STRAP_WAIT) begin
            assign_reg[BIT_STROBE_OFF] <= ~(pe_sync[PE_MODE_SELECT_A]);
        end else if (reg_write && reg_addr == REG_ASSIGN) begin
            assign_reg <= reg_wdata & ASSIGN_WMASK;
        end
    end

    // Direction and data registers for the general-purpose port E pins.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            dir_reg <= 8'h00;
            data_reg <= 8'h00;
        end else if (reg_write) begin
            if (reg_addr == REG_DIR) begin
                dir_reg <= reg_wdata;
            end
            if (reg_addr == REG_DATA) begin
                data_reg <= reg_wdata;
            end
        end
    end

    // Read data stands one cycle after the strobe; the status word shows mode and activity.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_read) begin
            unique case (reg_addr)
                REG_ASSIGN: reg_rdata <= assign_reg;
                REG_DIR: reg_rdata <= dir_reg;
                REG_DATA: reg_rdata <= pe_sync;
                REG_STATUS: reg_rdata <= {4'h0, busy, special, mode};
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // ************************************************************
    // Bus clock generator
    // ************************************************************
    logic [3:0] qcnt;
    logic [1:0] quarter;
    logic at_start;
    logic at_end;
    logic e_high;

    // The bus clock runs freely: low for quarters 0 and 1, high for 2 and 3.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            qcnt <= 4'h0;
            quarter <= 2'h0;
        end else if (qcnt == QUARTER_LAST) begin
            qcnt <= 4'h0;
            quarter <= quarter + 2'h1;
        end else begin
            qcnt <= qcnt + 4'h1;
        end
    end

    assign at_start = (quarter == 2'h0) && (qcnt == 4'h0);
    assign at_end = (quarter == QTR_LAST) && (qcnt == QUARTER_LAST);
    assign e_high = (quarter >= QTR_FIRST_HIGH);

    // ************************************************************
    // Access sequencer
    // ************************************************************
    ebc_state_t state;
    ebc_req_t cur;
    logic [1:0] stretch_left;
    logic first_period;
    logic illegal_write;
    logic take;
    logic [15:0] beat_addr;
    logic beat_size_n;
    logic low_byte_strobe_n_n;
    logic addr_phase;
    logic strobe_on;
    logic fin_pend;
    logic cap_pend;
    logic cap_wide;
    logic cap_low;

    // Returns the low-byte strobe level: low means the low data byte is valid.
    function automatic logic low_strobe(input logic a0, input logic size_n);
        low_strobe = ~(a0 ^ size_n);
    endfunction : low_strobe

    // Writes are refused in single-chip mode, with the direction pin off, or when they
    // would need the low-byte strobe before it is enabled.
    assign illegal_write = acc_req.write && (!expanded || !assign_reg[BIT_RW_ON]
        || (!assign_reg[BIT_LOW_BYTE_STROBE_N_ON]
        && !low_strobe(acc_req.addr[0], acc_req.byte_size_access_n)));
    assign acc_ready = (state == ST_IDLE) && at_start && strap_done;
    assign take = acc_valid && acc_ready;

    // Sequencer state: one beat normally, two beats for a narrow 16-bit transfer.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= ST_IDLE;
            cur <= '0;
            stretch_left <= 2'h0;
            first_period <= 1'b0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (take && expanded && !illegal_write) begin
                        state <= ST_HIGH;
                        cur <= acc_req;
                        stretch_left <= acc_req.stretch;
                        first_period <= 1'b1;
                    end
                end
                ST_HIGH, ST_LOW: begin
                    if (at_end) begin
                        first_period <= 1'b0;
                        if (stretch_left != 2'h0) begin
                            stretch_left <= stretch_left - 2'h1;
                        end else if (state == ST_HIGH && narrow && cur.byte_size_access_n) begin
                            state <= ST_LOW;
                            stretch_left <= cur.stretch;
                            first_period <= 1'b1;
                        end else begin
                            state <= ST_IDLE;
                        end
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    assign busy = (state != ST_IDLE);
    assign beat_addr = (state == ST_LOW) ? cur.addr + 16'h0001 : cur.addr;
    assign beat_size_n = narrow ? 1'b0 : cur.byte_size_access_n;
    assign low_byte_strobe_n_n = low_strobe(beat_addr[0], beat_size_n);
    assign addr_phase = busy && !e_high;
    // Unstretched: whole high phase; stretched: last quarter of the last period only.
    assign strobe_on = busy && stretch_left == 2'h0 && !first_period_block()
        && (cur.stretch == 2'h0 ? e_high : quarter == QTR_LAST);

    // A stretched access only strobes once its stretch periods have run out.
    function automatic logic first_period_block();
        first_period_block = (cur.stretch != 2'h0) && first_period;
    endfunction : first_period_block

    // Answers to the core: done or refused pulses, read data caught one edge after the
    // period's end. Pin flops and the two-flop synchroniser delay the bus by three edges,
    // so an earlier capture would miss the short strobe window of a stretched read.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            acc_done <= 1'b0;
            acc_refused <= 1'b0;
            acc_rdata <= 16'h0000;
            fin_pend <= 1'b0;
            cap_pend <= 1'b0;
            cap_wide <= 1'b0;
            cap_low <= 1'b0;
        end else begin
            acc_refused <= take && (!expanded || illegal_write);
            fin_pend <= busy && at_end && stretch_left == 2'h0
                && !(state == ST_HIGH && narrow && cur.byte_size_access_n);
            cap_pend <= busy && at_end && stretch_left == 2'h0 && !cur.write;
            cap_wide <= !narrow;
            cap_low <= state == ST_LOW || !cur.byte_size_access_n;
            acc_done <= fin_pend;
            if (cap_pend) begin
                if (cap_wide) begin
                    acc_rdata <= ad_sync;
                end else if (cap_low) begin
                    acc_rdata[7:0] <= ad_sync[15:8];
                end else begin
                    acc_rdata[15:8] <= ad_sync[15:8];
                end
            end
        end
    end

    // ************************************************************
    // Pin drivers
    // ************************************************************
    logic [7:0] next_pe_out;
    logic [7:0] next_pe_oe;
    logic [15:0] next_ad_out;
    logic [1:0] next_ad_oe;
    logic [7:0] wbyte;

    // Port E: general I/O first, then each enabled function overrides its bit.
    always_comb begin
        next_pe_out = data_reg;
        next_pe_oe = dir_reg;
        next_pe_out[PE_BUS_CLOCK_OUT] = e_high;
        next_pe_oe[PE_BUS_CLOCK_OUT] = 1'b1;
        if (!assign_reg[BIT_STROBE_OFF]) begin
            next_pe_out[PE_DBE] = ~strobe_on;
            next_pe_oe[PE_DBE] = 1'b1;
        end
        if (strap_done && assign_reg[BIT_QUEUE_ON]) begin
            next_pe_out[PE_MODE_SELECT_A] = e_high ? queue_state[2] : queue_state[0];
            next_pe_out[PE_MODE_SELECT_B] = e_high ? queue_state[3] : queue_state[1];
            next_pe_oe[PE_MODE_SELECT_A] = 1'b1;
            next_pe_oe[PE_MODE_SELECT_B] = 1'b1;
        end else if (!strap_done) begin
            next_pe_oe[PE_MODE_SELECT_A] = 1'b0;
            next_pe_oe[PE_MODE_SELECT_B] = 1'b0;
        end
        if (expanded && assign_reg[BIT_RW_ON]) begin
            next_pe_out[PE_RW] = ~(busy && cur.write);
            next_pe_oe[PE_RW] = 1'b1;
        end
        if (expanded && assign_reg[BIT_LOW_BYTE_STROBE_N_ON]) begin
            next_pe_out[PE_LOW_BYTE_STROBE_N] = busy ? low_byte_strobe_n_n : 1'b1;
            next_pe_oe[PE_LOW_BYTE_STROBE_N] = 1'b1;
        end
    end

    assign wbyte = (state == ST_LOW || !cur.byte_size_access_n) ? cur.wdata[7:0]
        : cur.wdata[15:8];

    // Address bus: address in every low phase of an access, because the external latch is open
    // whenever the bus clock is low; write data in the high phases; released on reads, except the low byte in narrow mode.
    always_comb begin
        next_ad_out = beat_addr;
        next_ad_oe = 2'b00;
        if (busy) begin
            if (narrow) begin
                next_ad_oe[0] = 1'b1;
                next_ad_oe[1] = addr_phase || cur.write;
                if (!addr_phase) begin
                    next_ad_out[15:8] = wbyte;
                end
            end else begin
                next_ad_oe = (addr_phase || cur.write) ? 2'b11 : 2'b00;
                if (!addr_phase) begin
                    next_ad_out = cur.wdata;
                end
            end
        end
    end

    // All pins leave from flip-flops so the strobe and bus clock never glitch.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pe_pin_out <= 8'h00;
            pe_pin_oe <= 8'h00;
            bus_ad_out <= 16'h0000;
            bus_ad_oe <= 2'b00;
        end else begin
            pe_pin_out <= next_pe_out;
            pe_pin_oe <= next_pe_oe;
            bus_ad_out <= next_ad_out;
            bus_ad_oe <= next_ad_oe;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);

    a_strobe_high_phase: assert property (
        pe_pin_oe[PE_DBE] && !pe_pin_out[PE_DBE] |-> pe_pin_out[PE_BUS_CLOCK_OUT])
        else $error("Strobe low outside bus clock high phase.");
    a_strobe_stretch: assert property (
        busy && cur.stretch != 2'h0 && strobe_on |-> quarter == QTR_LAST && !first_period)
        else $error("Stretched strobe outside final quarter.");
    a_strobe_select: assert property (
        assign_reg[BIT_STROBE_OFF] |=> pe_pin_oe[PE_DBE] == $past(dir_reg[PE_DBE]))
        else $error("Port E bit 7 not released to general I/O.");
    a_strobe_default: assert property (
        $rose(strap_done) && expanded |-> !assign_reg[BIT_STROBE_OFF])
        else $error("Strobe not enabled after expanded reset.");
    a_low_byte_strobe_n_value: assert property (
        busy && expanded && assign_reg[BIT_LOW_BYTE_STROBE_N_ON] |=> pe_pin_out[PE_LOW_BYTE_STROBE_N]
        == $past(~(beat_addr[0] ^ beat_size_n)))
        else $error("Low-byte strobe level wrong.");
    a_rw_dir: assert property (
        busy && cur.write && expanded && assign_reg[BIT_RW_ON] |=> !pe_pin_out[PE_RW])
        else $error("Direction pin not low during write.");
    a_bus_clock_out_period: assert property (
        $rose(pe_pin_out[PE_BUS_CLOCK_OUT]) |-> pe_pin_out[PE_BUS_CLOCK_OUT] [*6] ##1 !pe_pin_out[PE_BUS_CLOCK_OUT])
        else $error("Bus clock high phase wrong length.");
    a_mode_hold: assert property (
        strap_done |=> $stable(mode) && $stable(special))
        else $error("Mode changed after reset capture.");
    a_write_block: assert property (
        take && acc_req.write && !assign_reg[BIT_RW_ON] |=> acc_refused && !busy)
        else $error("Write accepted with direction pin off.");
    a_narrow_beats: assert property (
        state == ST_HIGH && narrow && cur.byte_size_access_n && at_end && stretch_left == 2'h0
        |=> state == ST_LOW && !acc_done)
        else $error("Narrow word did not take a second beat.");

    c_read_wide: cover property (acc_done && !cur.write && !narrow);
    c_write_narrow: cover property (state == ST_LOW && cur.write);
    c_stretched: cover property (strobe_on && cur.stretch != 2'h0);
    c_refused: cover property (acc_refused);

endmodule : ebc_bus_ctrl

`default_nettype wire

// >>> design/ebc_pkg.sv
// Package of constants and types for the external bus control block.
package ebc_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    // System clock period and bus clock period, both in picoseconds.
    localparam int CLK_PERIOD_PS = 8000;
    localparam int BUS_PERIOD_PS = 125000;
    // Cycles in one quarter of a bus clock period, rounded down.
    localparam int QUARTER_CYC_I = (BUS_PERIOD_PS / 4) / CLK_PERIOD_PS;
    localparam logic [3:0] QUARTER_LAST = 4'(QUARTER_CYC_I - 1);
    localparam logic [1:0] QTR_FIRST_HIGH = 2'h2;
    localparam logic [1:0] QTR_LAST = 2'h3;
    localparam logic [1:0] STRAP_WAIT = 2'h2;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [1:0] REG_ASSIGN = 2'h0;
    localparam logic [1:0] REG_DIR = 2'h1;
    localparam logic [1:0] REG_DATA = 2'h2;
    localparam logic [1:0] REG_STATUS = 2'h3;

    // Fields of the port E assignment register.
    localparam int BIT_STROBE_OFF = 7;
    localparam int BIT_QUEUE_ON = 5;
    localparam int BIT_LOW_BYTE_STROBE_N_ON = 3;
    localparam int BIT_RW_ON = 2;
    localparam logic [7:0] ASSIGN_RESET = 8'h80;
    localparam logic [7:0] ASSIGN_WMASK = 8'hac;

    // Port E pin positions.
    localparam int PE_DBE = 7;
    localparam int PE_MODE_SELECT_B = 6;
    localparam int PE_MODE_SELECT_A = 5;
    localparam int PE_BUS_CLOCK_OUT = 4;
    localparam int PE_LOW_BYTE_STROBE_N = 3;
    localparam int PE_RW = 2;

    // Operating modes taken from the mode pins at reset.
    typedef enum logic [1:0] {
        EBC_SINGLE = 2'b00,
        EBC_NARROW = 2'b01,
        EBC_PERIPH = 2'b10,
        EBC_WIDE = 2'b11
    } ebc_mode_t;

    // One bus access request from the core.
    typedef struct packed {
        logic write;
        logic byte_size_access_n;
        logic [1:0] stretch;
        logic [15:0] addr;
        logic [15:0] wdata;
    } ebc_req_t;

endpackage : ebc_pkg

// >>> verif/ebc_mem_model.sv
// Behavioural external memory on the multiplexed expansion bus.
`timescale 1ns/1ps
`default_nettype none
module ebc_mem_model (
    input wire logic sys_clk,
    input wire logic narrow,
    input wire logic [7:0] pe_pin_out,
    input wire logic [7:0] pe_pin_oe,
    input wire logic [15:0] bus_ad_out,
    output logic [15:0] bus_ad_in
);
    logic [7:0] mem [256];
    logic [15:0] addr, last, wd;
    logic wp, lat_lo;
    wire e_hi = pe_pin_out[4] & pe_pin_oe[4];
    // An undriven direction pin is pulled up, so it reads as a read.
    wire rd = !(pe_pin_oe[2] && !pe_pin_out[2]);
    wire gate = e_hi && rd && !(pe_pin_oe[7] && pe_pin_out[7]);
    wire [7:0] ev = {addr[7:1], 1'b0};
    initial begin
        wp = 1'b0;
        for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
    end
    // Address latch is transparent while the bus clock is low.
    always @(posedge sys_clk) begin
        if (!e_hi) begin
            addr <= bus_ad_out;
            lat_lo <= pe_pin_oe[3] ? pe_pin_out[3] : 1'b1;
        end
        if (e_hi && !rd) begin
            wd <= bus_ad_out;
            wp <= 1'b1;
        end else if (wp) begin
            wp <= 1'b0;
            if (narrow || !addr[0]) mem[addr[7:0]] <= wd[15:8];
            if (!narrow && !lat_lo) mem[addr[7:0] | 8'h01] <= wd[7:0];
        end
        last <= bus_ad_in;
    end
    // Released lines show the inverse of the last value, never a stale copy.
    assign bus_ad_in = !gate ? ~last : narrow ? {mem[addr[7:0]], ~last[7:0]} :
        {mem[ev], mem[ev | 8'h01]};
endmodule : ebc_mem_model
`default_nettype wire

// >>> verif/tb.sv
// Self-checking testbench for the external bus control block.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import ebc_pkg::*;
    logic sys_clk = 0, reset_n = 0, reg_write = 0, reg_read = 0, acc_valid = 0, dbg = 1;
    logic [1:0] reg_addr = 0, mode = 2'b11;
    logic [7:0] reg_wdata = 0, reg_rdata, pe_out, pe_oe, pe_in;
    logic [3:0] qs = 0, q_got, q_exp;
    ebc_req_t req = '0;
    logic acc_ready, acc_done, acc_refused, rd_v = 0, last_w = 0;
    logic [15:0] acc_rdata, ad_in, ad_out, w;
    logic [1:0] ad_oe;
    logic [23:0] exp_q[$], obs;
    int miscompares = 0, total_checks = 0, lo_cnt = 0;
    assign pe_in = (pe_oe & pe_out) | (~pe_oe & {1'b1, mode, 5'h1f});
    ebc_bus_ctrl uut (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .acc_valid(acc_valid), .acc_req(req), .acc_ready(acc_ready),
        .acc_done(acc_done), .acc_refused(acc_refused), .acc_rdata(acc_rdata),
        .queue_state(qs), .single_wire_debug_pin(dbg), .pe_pin_in(pe_in),
        .pe_pin_out(pe_out), .pe_pin_oe(pe_oe), .bus_ad_in(ad_in), .bus_ad_out(ad_out),
        .bus_ad_oe(ad_oe));
    ebc_mem_model mem (.sys_clk(sys_clk), .narrow(mode == 2'b01), .pe_pin_out(pe_out),
        .pe_pin_oe(pe_oe), .bus_ad_out(ad_out), .bus_ad_in(ad_in));
    // ************************************************************
    // Clock, closing report and scoreboard
    // ************************************************************
    initial begin
        forever #4 sys_clk = ~sys_clk;
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : summarize
    // Results are sampled mid-cycle so every registered output has settled.
    always @(negedge sys_clk) begin
        rd_v <= reg_read;
        if (acc_done || acc_refused || rd_v) begin
            obs = acc_refused ? {4'(lo_cnt), 20'h30000} : acc_done ?
                (last_w ? {4'(lo_cnt), 20'h20000} : {4'(lo_cnt), 4'h1, acc_rdata}) :
                {8'h04, 8'h00, reg_rdata};
            total_checks++;
            if (exp_q.size() == 0 || obs !== exp_q[0]) begin
                miscompares++;
                $display("CHECK FAILED at %0t got %h exp %h", $time, obs,
                    exp_q.size() ? exp_q[0] : 24'hx);
            end
            if (exp_q.size()) void'(exp_q.pop_front());
            lo_cnt = 0;
        end else if (pe_oe[7] && !pe_out[7]) begin
            lo_cnt++;
            total_checks++;
            // The strobe may only be low while the bus clock is high.
            if (pe_out[4] !== 1'b1) begin
                miscompares++;
                $display("CHECK FAILED at %0t got %h exp %h", $time, pe_out[4], 1'b1);
            end
        end
    end
    // ************************************************************
    // Bus tasks
    // ************************************************************
    task automatic reg_op(input logic wr, input logic [1:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_write <= wr;
        reg_read <= !wr;
        reg_addr <= a;
        reg_wdata <= d;
        if (!wr) exp_q.push_back({8'h04, 8'h00, d});
        @(posedge sys_clk);
        reg_write <= 0;
        reg_read <= 0;
    endtask : reg_op
    // Kind 1 read, 2 write, 3 refused; lo is the expected strobe-low cycle count.
    task automatic access(input logic wr, input logic sz_n, input logic [1:0] st,
        input logic [15:0] a, input logic [15:0] d, input logic [3:0] kind,
        input logic [3:0] lo);
        int n;
        exp_q.push_back({lo, kind, kind == 1 ? d : 16'h0});
        @(posedge sys_clk);
        acc_valid <= 1;
        req <= '{write: wr, byte_size_access_n: sz_n, stretch: st, addr: a, wdata: d};
        last_w <= wr;
        // Ready is looked at from the edge after the request rose, so the request
        // still stands at the edge where ready is sampled high.
        for (n = 0; n < 400; n++) begin
            @(posedge sys_clk);
            if (acc_ready) break;
        end
        acc_valid <= 0;
        for (n = 0; n < 400 && !(acc_done || acc_refused); n++) @(posedge sys_clk);
        if (n >= 400) begin
            miscompares++;
            summarize();
        end
        repeat (2) @(posedge sys_clk);
    endtask : access
    task automatic restart(input logic [1:0] m, input logic d);
        @(posedge sys_clk);
        reset_n <= 0;
        mode <= m;
        dbg <= d;
        repeat (10) @(posedge sys_clk);
        reset_n <= 1;
        repeat (4) @(posedge sys_clk);
    endtask : restart
    // ************************************************************
    // Scenarios
    // ************************************************************
    initial begin
        void'($urandom(32'h8f9e006a));
        w = 16'($urandom);
        restart(2'b11, 1'b1);
        reg_op(0, REG_STATUS, 8'h03);
        reg_op(0, REG_ASSIGN, 8'h00);
        access(1, 1, 0, 16'h0010, w, 3, 0);
        $display("wide reset and refusal done");
        reg_op(1, REG_ASSIGN, 8'h04);
        reg_op(0, REG_ASSIGN, 8'h04);
        access(1, 1, 0, 16'h0020, w, 3, 0);
        access(1, 0, 0, 16'h0020, w, 2, 6);
        reg_op(1, REG_ASSIGN, 8'h0c);
        access(1, 0, 1, 16'h0021, ~w, 2, 3);
        access(0, 1, 0, 16'h0020, {w[15:8], ~w[7:0]}, 1, 6);
        access(1, 1, 0, 16'h0030, w, 2, 6);
        access(0, 1, 2, 16'h0030, w, 1, 3);
        $display("wide accesses done");
        reg_op(1, REG_ASSIGN, 8'h2c);
        // Queue state must follow the bus clock phase on the two mode pins.
        repeat (8) begin
            qs <= 4'($urandom);
            repeat (2) @(posedge sys_clk);
            @(negedge sys_clk);
            q_got = {pe_oe[6:5], pe_out[6:5]};
            q_exp = {2'b11, pe_out[4] ? qs[3:2] : qs[1:0]};
            total_checks++;
            if (q_got !== q_exp) begin
                miscompares++;
                $display("CHECK FAILED at %0t got %h exp %h", $time, q_got, q_exp);
            end
            @(posedge sys_clk);
        end
        $display("queue tracking done");
        reg_op(1, REG_ASSIGN, 8'h8c);
        access(0, 1, 0, 16'h0030, w, 1, 0);
        access(0, 1, 0, 16'h0044, 16'h1e1f, 1, 0);
        $display("strobe deselect done");
        restart(2'b01, 1'b0);
        reg_op(0, REG_STATUS, 8'h05);
        reg_op(1, REG_ASSIGN, 8'h0c);
        access(0, 1, 0, 16'h0050, 16'h0a0b, 1, 12);
        $display("narrow mode done");
        restart(2'b00, 1'b1);
        access(0, 1, 0, 16'h0050, 16'h0, 3, 0);
        $display("single chip done");
        summarize();
    end
endmodule : tb
`default_nettype wire
